// file: design/pcs_ctrl.sv
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Lock rises a programmed slow-clock count after config write or wake.
// - VCO ratio is (mul+1)/div, or 2*(mul+1) when div is zero.
// - Option bit one adds a divide-by-two after the VCO.
// - Option bit zero selects the VCO range, low bands when set.
// - Option bit two disables wide-bandwidth mode when set.
// - Source bit picks oscillator 0 or 1; enable bit runs the synthesiser.
// - Main oscillator mode 0 external clock, 4 to 7 crystal gains G0-G3.
// - Main oscillator startup codes 0-6 give 0 to 16384 RC cycles.
// - Slow crystal control resets only on power-on reset.
// - Slow crystal runs when its enable bit is one.
// - Slow crystal mode 0 external clock, 1 crystal, others reserved.
// - Slow crystal startup codes 0-7 give 0 to 524288 RC cycles.
// - Event flags set on rising edges of their status bits.
// - Clock-ready flag follows its status level; clearing it does nothing.
// - Enable sets mask, disable clears it, clear drops events, mask reads back.
// - Pending view reads one for a pending event, zero otherwise.
// - Mask-ready event rises once clock gating matches the mask registers.
// - Lock events rise when a synthesiser becomes locked.
// - Writing clock select clears clock-ready until the switch completes.
module pcs_ctrl
  import pcs_pkg::*;
(
  // Clock and resets.
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic por_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timing strobes, one cycle each, synchronous to ref_clk.
  input wire logic rc_tick,
  input wire logic slow_tick,
  // Analog and clock system levels.
  input wire logic osc0_enable,
  input wire logic osc1_enable,
  input wire logic [1:0] synth_wake,
  input wire logic brownout_detected,
  input wire logic gating_applied,
  input wire logic clock_switch_ack,
  // Synthesiser controls.
  output logic [1:0] synth_enable,
  output logic [1:0] synth_source_select,
  output logic [1:0] vco_range_low,
  output logic [1:0] post_divide_en,
  output logic [1:0] wide_bw_en,
  output logic [1:0][5:0] vco_ratio_num,
  output logic [1:0][3:0] vco_ratio_den,
  // Oscillator controls.
  output logic [1:0] osc_crystal_en,
  output logic [1:0][1:0] osc_gain,
  output logic [1:0] crystal_output_pin_free,
  output logic slow_crystal_enable,
  output logic slow_crystal_xtal_en,
  output logic slow_crystal_output_pin_free,
  output logic [31:0] clock_divider_select,
  output logic [31:0] status_out
);

  // ==========================================================================
  // Bus decode.
  logic [31:0] pll_cfg_reg [2];
  logic [31:0] osc_ctrl_reg [2];
  logic [31:0] slow_crystal_control_reg, clksel_reg, mask_reg, pend_reg, status_reg, status_prev_reg;
  logic [19:0] osc_cnt_reg [2];
  logic [19:0] o32_cnt_reg;
  logic [5:0] lock_cnt_reg [2];
  logic [1:0] osc_rdy_reg, lock_reg, pll_wr, osc_wr;
  logic o32_rdy_reg;
  logic clock_switch_done_reg;
  logic access, wr_go, hit;
  logic [31:0] rd_mux, status_next, wdat_evt;

  // One wait state: the answer comes in the second access cycle, so every output is a flop.
  assign access = psel & penable;
  assign wr_go = access & pready & pwrite;
  assign wdat_evt = pwdata & PCS_EVT_MASK;
  assign pll_wr[0] = wr_go & (paddr == PCS_OFF_PLL0);
  assign pll_wr[1] = wr_go & (paddr == PCS_OFF_PLL1);
  assign osc_wr[0] = wr_go & (paddr == PCS_OFF_OSC0);
  assign osc_wr[1] = wr_go & (paddr == PCS_OFF_OSC1);

  // Read mux; write-only registers read as zero.
  always_comb
  begin
    hit = 1'b1;
    rd_mux = PCS_RESET_VALUE;
    case (paddr)
      PCS_OFF_CLKSEL: rd_mux = clksel_reg;
      PCS_OFF_PLL0: rd_mux = pll_cfg_reg[0];
      PCS_OFF_PLL1: rd_mux = pll_cfg_reg[1];
      PCS_OFF_OSC0: rd_mux = osc_ctrl_reg[0];
      PCS_OFF_OSC1: rd_mux = osc_ctrl_reg[1];
      PCS_OFF_OSC32: rd_mux = slow_crystal_control_reg;
      PCS_OFF_IER, PCS_OFF_IDR, PCS_OFF_ICR: rd_mux = PCS_RESET_VALUE;
      PCS_OFF_IMR: rd_mux = mask_reg;
      PCS_OFF_ISR: rd_mux = pend_reg;
      PCS_OFF_STATUS: rd_mux = status_reg;
      default: hit = 1'b0;
    endcase
  end

  // ==========================================================================
  // APB answer.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= PCS_RESET_VALUE;
    end
    else
    begin
      pready <= access & ~pready;
      pslverr <= access & ~pready & ~hit;
      if (access & ~pready & ~pwrite & hit)
        prdata <= rd_mux;
      else if (!access)
        prdata <= PCS_RESET_VALUE;
    end
  end

  // ==========================================================================
  // Synthesiser and main oscillator control registers.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < 2; i++)
      begin
        pll_cfg_reg[i] <= PCS_RESET_VALUE;
        osc_ctrl_reg[i] <= PCS_RESET_VALUE;
      end
      clksel_reg <= PCS_RESET_VALUE;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        // Reserved fields are dropped so they always read zero.
        if (pll_wr[i])
          pll_cfg_reg[i] <= pwdata & PCS_PLL_WMASK;
        if (osc_wr[i])
          osc_ctrl_reg[i] <= pwdata & PCS_OSC_WMASK;
      end
      if (wr_go && paddr == PCS_OFF_CLKSEL)
        clksel_reg <= pwdata;
    end
  end

  // Slow crystal control lives on the power-on reset so warm resets keep it.
  always_ff @(posedge ref_clk or negedge por_n)
  begin
    if (!por_n)
      slow_crystal_control_reg <= PCS_RESET_VALUE;
    else if (wr_go && paddr == PCS_OFF_OSC32)
      slow_crystal_control_reg <= pwdata & PCS_O32_WMASK;
  end

  // ==========================================================================
  // Main oscillator startup counters, counted in RC cycles.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < 2; i++)
      begin
        osc_cnt_reg[i] <= 20'h0_0000;
        osc_rdy_reg[i] <= 1'b0;
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (!(i == 0 ? osc0_enable : osc1_enable))
        begin
          osc_cnt_reg[i] <= 20'h0_0000;
          osc_rdy_reg[i] <= 1'b0;
        end
        else if (osc_cnt_reg[i] >= PCS_OSC_SU_TABLE[osc_ctrl_reg[i][PCS_OSC_SU_LO +: 3]])
          osc_rdy_reg[i] <= 1'b1;
        else if (rc_tick)
          osc_cnt_reg[i] <= osc_cnt_reg[i] + 20'h0_0001;
      end
    end
  end

  // Slow crystal startup counter; shares the power-on reset with its control.
  always_ff @(posedge ref_clk or negedge por_n)
  begin
    if (!por_n)
    begin
      o32_cnt_reg <= 20'h0_0000;
      o32_rdy_reg <= 1'b0;
    end
    else if (!slow_crystal_control_reg[PCS_O32_EN])
    begin
      o32_cnt_reg <= 20'h0_0000;
      o32_rdy_reg <= 1'b0;
    end
    else if (o32_cnt_reg >= PCS_O32_SU_TABLE[slow_crystal_control_reg[PCS_O32_SU_LO +: 3]])
      o32_rdy_reg <= 1'b1;
    else if (rc_tick)
      o32_cnt_reg <= o32_cnt_reg + 20'h0_0001;
  end

  // ==========================================================================
  // Lock delay: restarted by a config write or a wake re-enable, counted in slow cycles.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < 2; i++)
      begin
        lock_cnt_reg[i] <= 6'h00;
        lock_reg[i] <= 1'b0;
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (!pll_cfg_reg[i][PCS_PLL_EN] || pll_wr[i] || synth_wake[i])
        begin
          lock_cnt_reg[i] <= 6'h00;
          lock_reg[i] <= 1'b0;
        end
        else if (lock_cnt_reg[i] >= pll_cfg_reg[i][PCS_PLL_CNT_LO +: 6])
          lock_reg[i] <= 1'b1;
        else if (slow_tick)
          lock_cnt_reg[i] <= lock_cnt_reg[i] + 6'h01;
      end
    end
  end

  // Clock-ready drops on a clock select write; the completion wins if both coincide.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      clock_switch_done_reg <= 1'b1;
    else if (clock_switch_ack)
      clock_switch_done_reg <= 1'b1;
    else if (wr_go && paddr == PCS_OFF_CLKSEL)
      clock_switch_done_reg <= 1'b0;
  end

  // ==========================================================================
  // Status word and event flags.
  always_comb
  begin
    status_next = PCS_RESET_VALUE;
    status_next[PCS_B_SYNTH0_LOCKED] = lock_reg[0];
    status_next[PCS_B_SYNTH1_LOCKED] = lock_reg[1];
    status_next[PCS_B_CLOCK_SWITCH_DONE] = clock_switch_done_reg;
    status_next[PCS_B_GATING_APPLIED] = gating_applied;
    status_next[PCS_B_OSC0] = osc_rdy_reg[0];
    status_next[PCS_B_OSC1] = osc_rdy_reg[1];
    status_next[PCS_B_OSC32] = o32_rdy_reg;
    status_next[PCS_B_BOD] = brownout_detected;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      status_reg <= PCS_RESET_VALUE;
      status_prev_reg <= PCS_RESET_VALUE;
    end
    else
    begin
      status_reg <= status_next;
      status_prev_reg <= status_reg;
    end
  end

  // Pending events: rising edge sets, clear register drops, a coinciding set wins.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      pend_reg <= PCS_RESET_VALUE;
    else
    begin
      for (int b = 0; b < 32; b++)
      begin
        if (b == PCS_B_CLOCK_SWITCH_DONE)
          pend_reg[b] <= status_reg[b];
        else if (PCS_EVT_MASK[b] && status_reg[b] && !status_prev_reg[b])
          pend_reg[b] <= 1'b1;
        else if (wr_go && paddr == PCS_OFF_ICR && wdat_evt[b])
          pend_reg[b] <= 1'b0;
      end
    end
  end

  // Enable mask: set and clear registers act only on bits written one.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      mask_reg <= PCS_RESET_VALUE;
    else if (wr_go && paddr == PCS_OFF_IER)
      mask_reg <= mask_reg | wdat_evt;
    else if (wr_go && paddr == PCS_OFF_IDR)
      mask_reg <= mask_reg & ~wdat_evt;
  end

  // ==========================================================================
  // Registered control outputs to the analog cells.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      synth_enable <= 2'b00;
      synth_source_select <= 2'b00;
      vco_range_low <= 2'b00;
      post_divide_en <= 2'b00;
      wide_bw_en <= 2'b00;
      vco_ratio_num <= '0;
      vco_ratio_den <= '0;
      osc_crystal_en <= 2'b00;
      osc_gain <= '0;
      crystal_output_pin_free <= 2'b00;
      clock_divider_select <= PCS_RESET_VALUE;
      status_out <= PCS_RESET_VALUE;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        synth_enable[i] <= pll_cfg_reg[i][PCS_PLL_EN];
        synth_source_select[i] <= pll_cfg_reg[i][PCS_PLL_SRC];
        vco_range_low[i] <= pll_cfg_reg[i][PCS_PLL_OPT_LO];
        post_divide_en[i] <= pll_cfg_reg[i][PCS_PLL_OPT_LO + 1];
        wide_bw_en[i] <= ~pll_cfg_reg[i][PCS_PLL_OPT_LO + 2];
        // A zero divider means a doubled multiplier over a unit divider.
        if (pll_cfg_reg[i][PCS_PLL_DIV_LO +: 4] == 4'h0)
        begin
          vco_ratio_num[i] <= {1'b0, pll_cfg_reg[i][PCS_PLL_MUL_LO +: 4], 1'b0} + 6'h02;
          vco_ratio_den[i] <= 4'h1;
        end
        else
        begin
          vco_ratio_num[i] <= {2'b00, pll_cfg_reg[i][PCS_PLL_MUL_LO +: 4]} + 6'h01;
          vco_ratio_den[i] <= pll_cfg_reg[i][PCS_PLL_DIV_LO +: 4];
        end
        // Reserved modes 1 to 3 keep the crystal off but, unlike external clock, leave the output pin in use.
        osc_crystal_en[i] <= osc_ctrl_reg[i][PCS_OSC_MODE_LO + 2];
        osc_gain[i] <= osc_ctrl_reg[i][PCS_OSC_MODE_LO +: 2];
        crystal_output_pin_free[i] <= (osc_ctrl_reg[i][PCS_OSC_MODE_LO +: 3] == PCS_MODE_EXT);
      end
      clock_divider_select <= clksel_reg;
      status_out <= status_reg;
    end
  end

  // Slow crystal outputs follow the power-on reset like their register.
  always_ff @(posedge ref_clk or negedge por_n)
  begin
    if (!por_n)
    begin
      slow_crystal_enable <= 1'b0;
      slow_crystal_xtal_en <= 1'b0;
      slow_crystal_output_pin_free <= 1'b0;
    end
    else
    begin
      slow_crystal_enable <= slow_crystal_control_reg[PCS_O32_EN];
      slow_crystal_xtal_en <= (slow_crystal_control_reg[PCS_O32_MODE_LO +: 3] == PCS_MODE_XTAL32);
      slow_crystal_output_pin_free <= (slow_crystal_control_reg[PCS_O32_MODE_LO +: 3] == PCS_MODE_EXT);
    end
  end

endmodule
`default_nettype wire

// file: design/pcs_pkg.sv
package pcs_pkg;
  // ==========================================================================
  // Register byte offsets.
  localparam logic [11:0] PCS_OFF_CLKSEL = 12'h0004;
  localparam logic [11:0] PCS_OFF_PLL0 = 12'h0020;
  localparam logic [11:0] PCS_OFF_PLL1 = 12'h0024;
  localparam logic [11:0] PCS_OFF_OSC0 = 12'h0028;
  localparam logic [11:0] PCS_OFF_OSC1 = 12'h002C;
  localparam logic [11:0] PCS_OFF_OSC32 = 12'h0030;
  localparam logic [11:0] PCS_OFF_IER = 12'h0040;
  localparam logic [11:0] PCS_OFF_IDR = 12'h0044;
  localparam logic [11:0] PCS_OFF_IMR = 12'h0048;
  localparam logic [11:0] PCS_OFF_ISR = 12'h004C;
  localparam logic [11:0] PCS_OFF_ICR = 12'h0050;
  localparam logic [11:0] PCS_OFF_STATUS = 12'h0054;
  // ==========================================================================
  // Synthesiser configuration fields.
  localparam int PCS_PLL_EN = 0;
  localparam int PCS_PLL_SRC = 1;
  localparam int PCS_PLL_OPT_LO = 2;
  localparam int PCS_PLL_DIV_LO = 8;
  localparam int PCS_PLL_MUL_LO = 16;
  localparam int PCS_PLL_CNT_LO = 24;
  localparam logic [31:0] PCS_PLL_WMASK = 32'h3F0F_0F1F;
  // Main oscillator control fields.
  localparam int PCS_OSC_MODE_LO = 0;
  localparam int PCS_OSC_SU_LO = 8;
  localparam logic [31:0] PCS_OSC_WMASK = 32'h0000_0707;
  // Slow crystal control fields.
  localparam int PCS_O32_EN = 0;
  localparam int PCS_O32_MODE_LO = 8;
  localparam int PCS_O32_SU_LO = 16;
  localparam logic [31:0] PCS_O32_WMASK = 32'h0007_0701;
  // ==========================================================================
  // Status and event bit positions.
  localparam int PCS_B_SYNTH0_LOCKED = 0;
  localparam int PCS_B_SYNTH1_LOCKED = 1;
  localparam int PCS_B_CLOCK_SWITCH_DONE = 5;
  localparam int PCS_B_GATING_APPLIED = 6;
  localparam int PCS_B_OSC0 = 7;
  localparam int PCS_B_OSC1 = 8;
  localparam int PCS_B_OSC32 = 9;
  localparam int PCS_B_BOD = 16;
  localparam logic [31:0] PCS_EVT_MASK = 32'h0001_03E3;
  localparam logic [31:0] PCS_RESET_VALUE = 32'h0000_0000;
  // ==========================================================================
  // Startup counts in RC cycles, indexed by code.
  localparam logic [19:0] PCS_OSC_SU_TABLE [8] = '{20'h0_0000, 20'h0_0040, 20'h0_0080, 20'h0_0800,
                                                   20'h0_1000, 20'h0_2000, 20'h0_4000, 20'h0_4000};
  localparam logic [19:0] PCS_O32_SU_TABLE [8] = '{20'h0_0000, 20'h0_0080, 20'h0_2000, 20'h0_4000,
                                                   20'h1_0000, 20'h2_0000, 20'h4_0000, 20'h8_0000};
  localparam logic [2:0] PCS_MODE_EXT = 3'h0;
  localparam logic [2:0] PCS_MODE_XTAL32 = 3'h1;
endpackage

// file: sim/pcs_ctrl_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Port checks for the clock control block.
module pcs_ctrl_sva
  import pcs_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // Register bus.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Levels and strobes from outside.
  input wire logic osc0_enable,
  input wire logic brownout_detected,
  input wire logic gating_applied,
  input wire logic clock_switch_ack,
  // Synthesiser outputs and status.
  input wire logic [1:0] synth_enable,
  input wire logic [1:0][5:0] vco_ratio_num,
  input wire logic [1:0][3:0] vco_ratio_den,
  input wire logic [31:0] status_out
);
  logic wr_done;
  logic [31:0] pll0_seen;
  // A write lands at the edge where the access completes.
  assign wr_done = psel && penable && pready && pwrite;
  // Keep the last synthesiser 0 word, since the ratio shows two edges later.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      pll0_seen <= 32'h0000_0000;
    else if (wr_done && paddr == PCS_OFF_PLL0)
      pll0_seen <= pwdata;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_pready_once; pready |=> !pready; endproperty
  property p_one_wait; psel && $rose(penable) |=> pready; endproperty
  property p_err_ready; pslverr |-> pready; endproperty
  property p_idle_zero; !psel && !$past(psel) |-> prdata == 32'h0000_0000; endproperty
  property p_pll_ratio;
    wr_done && paddr == PCS_OFF_PLL0 |-> ##2
      vco_ratio_num[0] == 6'(({2'h0, pll0_seen[19:16]} + 6'h01) << (pll0_seen[11:8] == 4'h0)) &&
      vco_ratio_den[0] == ((pll0_seen[11:8] == 4'h0) ? 4'h1 : pll0_seen[11:8]);
  endproperty
  property p_lock_off; !synth_enable[0] [*6] |-> !status_out[PCS_B_SYNTH0_LOCKED]; endproperty
  property p_osc_off; !osc0_enable [*6] |-> !status_out[PCS_B_OSC0]; endproperty
  property p_ck_clear; wr_done && paddr == PCS_OFF_CLKSEL |-> ##3 !status_out[PCS_B_CLOCK_SWITCH_DONE]; endproperty
  property p_ck_back; clock_switch_ack |-> ##[1:3] status_out[PCS_B_CLOCK_SWITCH_DONE]; endproperty
  property p_bod_seen; $rose(brownout_detected) |-> ##[1:3] status_out[PCS_B_BOD]; endproperty
  property p_mask_level; gating_applied [*4] |-> status_out[PCS_B_GATING_APPLIED]; endproperty
  a_pready_once: assert property (p_pready_once) else $error("long ready");
  a_one_wait: assert property (p_one_wait) else $error("late ready");
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  a_idle_zero: assert property (p_idle_zero) else $error("idle data not zero");
  a_pll_ratio: assert property (p_pll_ratio) else $error("ratio wrong");
  a_lock_off: assert property (p_lock_off) else $error("lock while disabled");
  a_osc_off: assert property (p_osc_off) else $error("ready while disabled");
  a_ck_clear: assert property (p_ck_clear) else $error("clock ready not cleared");
  a_ck_back: assert property (p_ck_back) else $error("clock ready not restored");
  a_bod_seen: assert property (p_bod_seen) else $error("brownout not reported");
  a_mask_level: assert property (p_mask_level) else $error("gating not reported");
  c_refused: cover property (pslverr);
  c_locked: cover property ($rose(status_out[PCS_B_SYNTH0_LOCKED]));
  c_switch: cover property (clock_switch_ack);
endmodule
// Attach the checks to every instance of the block.
bind pcs_ctrl pcs_ctrl_sva u_pcs_sva (
  .ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .osc0_enable,
  .brownout_detected, .gating_applied, .clock_switch_ack, .synth_enable, .vco_ratio_num, .vco_ratio_den, .status_out
);
`default_nettype wire

// file: sim/pcs_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Self-checking bench for the clock control block.
module pcs_ctrl_tb;
  import pcs_pkg::*;
  localparam int SLOW_DIV = 4;
  localparam int LIMIT = 100000;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic ref_clk, pready, pslverr, err, rc_tick, slow_tick, clock_switch_ack;
  logic resetn = 1'b0, por_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic brownout_detected = 1'b0, gating_applied = 1'b0;
  logic slow_crystal_enable, slow_crystal_xtal_en, slow_crystal_output_pin_free;
  logic [1:0] osc_en = 2'h0, synth_wake = 2'h0;
  logic [1:0] synth_enable, synth_source_select, vco_range_low, post_divide_en, wide_bw_en;
  logic [1:0] osc_crystal_en, crystal_output_pin_free;
  logic [1:0][5:0] vco_ratio_num;
  logic [1:0][3:0] vco_ratio_den;
  logic [1:0][1:0] osc_gain;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd, clock_divider_select, status_out;
  int n_mismatch, comparisons, cyc, n, m, lo;
  int su0 [8] = '{0, 64, 128, 2048, 4096, 8192, 16384, 0};
  int su32 [3] = '{0, 128, 8192};
  logic [31:0] cfg [2] = '{32'h0503_0015, 32'h0205_030B};
  // ============================================================
  // Block under test and its far side.
  pcs_ctrl dut (
    .ref_clk, .resetn, .por_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rc_tick, .slow_tick, .osc0_enable(osc_en[0]), .osc1_enable(osc_en[1]), .synth_wake, .brownout_detected,
    .gating_applied, .clock_switch_ack, .synth_enable, .synth_source_select, .vco_range_low, .post_divide_en,
    .wide_bw_en, .vco_ratio_num, .vco_ratio_den, .osc_crystal_en, .osc_gain, .crystal_output_pin_free,
    .slow_crystal_enable, .slow_crystal_xtal_en, .slow_crystal_output_pin_free, .clock_divider_select, .status_out
  );
  pcs_far_model #(.SLOW_DIV(SLOW_DIV)) far (
    .ref_clk, .resetn, .clock_divider_select, .clock_switch_ack, .rc_tick, .slow_tick
  );
  // Free-running 200 MHz clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // A hang ends the run as a failure.
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      n_mismatch = n_mismatch + 1;
      conclude();
    end
  end
  // ============================================================
  // Comparison and bus tasks.
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic span(input int v, input int lo_v, input int hi_v);
    chk(32'(v >= lo_v && v <= hi_v), 32'h0000_0001);
  endtask
  // Setup, then access held until ready.
  task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] msk, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd & msk, exp);
  endtask
  // Counts edges until a status bit reaches v.
  task automatic wait_bit(input int b, input logic v, output int cnt);
    cnt = 0;
    while (status_out[b] !== v)
    begin
      @(posedge ref_clk);
      cnt = cnt + 1;
    end
  endtask
  // ============================================================
  // Main sequence.
  initial
  begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    por_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rdc(PCS_OFF_ISR, ALL, 32'h0000_0020);
    rdc(PCS_OFF_STATUS, ALL, 32'h0000_0020);
    apb(1'b0, 12'h03C, 32'h0000_0000);
    chk({rd[30:0], err}, 32'h0000_0001);
    rdc(PCS_OFF_IER, ALL, 32'h0000_0000);
    wr(PCS_OFF_IER, ALL);
    rdc(PCS_OFF_IMR, ALL, PCS_EVT_MASK);
    wr(PCS_OFF_IDR, 32'h0000_0003);
    wr(PCS_OFF_IER, 32'h0000_0000);
    rdc(PCS_OFF_IMR, ALL, PCS_EVT_MASK & 32'hFFFF_FFFC);
    // Both synthesisers, two settings each.
    for (int s = 0; s < 2; s++)
      for (int i = 0; i < 2; i++)
      begin
        wr(PCS_OFF_PLL0 + 12'(4 * s), cfg[i]);
        wait_bit(s, 1'b0, n);
        span(n, 0, 4);
        wait_bit(s, 1'b1, m);
        lo = int'(cfg[i][29:24]) * SLOW_DIV;
        span(n + m, lo - SLOW_DIV, lo + 6);
        rdc(PCS_OFF_PLL0 + 12'(4 * s), ALL, cfg[i] & PCS_PLL_WMASK);
        chk(32'({synth_source_select[s], synth_enable[s]}), 32'(cfg[i][1:0]));
        chk(32'({wide_bw_en[s], post_divide_en[s], vco_range_low[s]}), 32'({~cfg[i][4], cfg[i][3:2]}));
      end
    rdc(PCS_OFF_ISR, 32'h0000_0023, 32'h0000_0023);
    wr(PCS_OFF_ICR, 32'h0000_0023);
    rdc(PCS_OFF_ISR, 32'h0000_0023, 32'h0000_0020);
    synth_wake <= 2'b01;
    @(posedge ref_clk);
    synth_wake <= 2'b00;
    wait_bit(0, 1'b0, n);
    wait_bit(0, 1'b1, m);
    span(n + m, SLOW_DIV, 2 * SLOW_DIV + 7);
    wr(PCS_OFF_PLL0, cfg[1]);
    wait_bit(0, 1'b0, n);
    span(n, 0, 4);
    wr(PCS_OFF_PLL0, cfg[1] & 32'hFFFF_FFFE);
    repeat (40) @(posedge ref_clk);
    chk(32'(status_out[0]), 32'h0000_0000);
    // Every mode and startup codes 0 to 6 of both main oscillators.
    for (int s = 0; s < 2; s++)
      for (int k = 0; k < 8; k++)
      begin
        wr(PCS_OFF_OSC0 + 12'(4 * s), 32'(((k % 7) << 8) | k));
        osc_en[s] <= 1'b1;
        wait_bit(PCS_B_OSC0 + s, 1'b1, n);
        span(n, su0[k % 7], su0[k % 7] + 6);
        chk(32'(osc_crystal_en[s]), 32'(k >> 2));
        if (k >= 4)
          chk(32'(osc_gain[s]), 32'(k & 3));
        if (k == 0 || k >= 4)
          chk(32'(crystal_output_pin_free[s]), 32'(k == 0));
        osc_en[s] <= 1'b0;
        repeat (8) @(posedge ref_clk);
      end
    rdc(PCS_OFF_ISR, 32'h0000_0180, 32'h0000_0180);
    // Slow crystal: startup codes, enable, mode and its own reset.
    for (int k = 0; k < 3; k++)
    begin
      wr(PCS_OFF_OSC32, 32'((k << 16) | 32'h0000_0101));
      wait_bit(PCS_B_OSC32, 1'b1, n);
      span(n, su32[k], su32[k] + 6);
      chk(32'({slow_crystal_enable, slow_crystal_xtal_en, slow_crystal_output_pin_free}), 32'h0000_0006);
      wr(PCS_OFF_OSC32, 32'h0000_0000);
      repeat (8) @(posedge ref_clk);
      chk(32'(status_out[PCS_B_OSC32]), 32'h0000_0000);
    end
    wr(PCS_OFF_OSC32, 32'h0000_0001);
    resetn <= 1'b0;
    @(posedge ref_clk);
    resetn <= 1'b1;
    rdc(PCS_OFF_OSC32, ALL, 32'h0000_0001);
    chk(32'({slow_crystal_xtal_en, slow_crystal_output_pin_free}), 32'h0000_0001);
    por_n <= 1'b0;
    @(posedge ref_clk);
    por_n <= 1'b1;
    rdc(PCS_OFF_OSC32, ALL, 32'h0000_0000);
    // Clock switch, then brownout and gating events.
    wr(PCS_OFF_CLKSEL, 32'h0000_0101);
    wait_bit(PCS_B_CLOCK_SWITCH_DONE, 1'b0, n);
    span(n, 0, 4);
    wait_bit(PCS_B_CLOCK_SWITCH_DONE, 1'b1, m);
    span(m, 1, 24);
    chk(clock_divider_select, 32'h0000_0101);
    brownout_detected <= 1'b1;
    gating_applied <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rdc(PCS_OFF_ISR, 32'h0001_0040, 32'h0001_0040);
    wr(PCS_OFF_ICR, 32'h0001_0040);
    rdc(PCS_OFF_ISR, 32'h0001_0040, 32'h0000_0000);
    brownout_detected <= 1'b0;
    gating_applied <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rdc(PCS_OFF_STATUS, 32'h0001_0040, 32'h0000_0000);
    conclude();
  end
endmodule
`default_nettype wire

// file: sim/pcs_far_model.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Far side: tick strobes and the answer to a clock switch.
module pcs_far_model #(
  parameter int SLOW_DIV = 4,
  parameter int ACK_DELAY = 9
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // Clock switch.
  input wire logic [31:0] clock_divider_select,
  output logic clock_switch_ack,
  // Tick strobes.
  output logic rc_tick,
  output logic slow_tick
);
  int div_cnt, ack_cnt;
  logic [31:0] sel_seen;
  // The RC strobe runs every cycle so long startup codes stay short.
  assign rc_tick = 1'b1;
  // Slow strobes come every SLOW_DIV cycles; a switch is never answered at once.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      div_cnt <= 0;
      ack_cnt <= 0;
      slow_tick <= 1'b0;
      clock_switch_ack <= 1'b0;
      sel_seen <= 32'h0000_0000;
    end
    else
    begin
      div_cnt <= (div_cnt == SLOW_DIV - 1) ? 0 : div_cnt + 1;
      slow_tick <= (div_cnt == SLOW_DIV - 1);
      sel_seen <= clock_divider_select;
      clock_switch_ack <= (ack_cnt == 1);
      if (sel_seen != clock_divider_select)
        ack_cnt <= ACK_DELAY;
      else if (ack_cnt != 0)
        ack_cnt <= ack_cnt - 1;
    end
  end
endmodule
`default_nettype wire
